// file: rtl/gfc_device.sv
// counter end: reference select, dividers, arm/gate and accumulator
`timescale 1ns/10ps
`include "gfc_consts.svh"

module gfc_device (
	// clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   rst_n_i,
	// host port
	gfc_if.dev                          port,
	// signal inputs
	input  wire logic                   source_freq_i,
	input  wire logic                   analyzer_freq_in_i,
	input  wire logic                   ext_ref_i,
	input  wire logic [`GFC_OPT_W-1:0]  option_sw_i,
	// indicators and clocks
	output logic                        ext_ref_led_o,
	output logic                        armed_led_o,
	output logic                        gate_led_o,
	output logic                        overflow_led_o,
	output logic                        cpu_clk_o
);

	function automatic logic falls(input logic prev, input logic cur);
		falls = prev & ~cur;
	endfunction

	function automatic logic dec_out(input logic [3:0] cnt);
		dec_out = (cnt >= `GFC_DEC_HALF);
	endfunction

	logic [1:0]                  osc_phase;
	logic                        int_ref;
	logic                        int_ref_prev;
	logic                        ext_prev;
	logic [7:0]                  ext_timer;
	logic                        ext_present;
	logic                        ref_sel;
	logic                        ref_prev;
	logic                        ref_rise;
	logic                        meas_in;
	logic [3:0]                  dec_cnt [1:`GFC_STAGES];
	logic [`GFC_STAGES:0]        div_out;
	logic [`GFC_STAGES:0]        div_prev;
	logic [2:0]                  period_sel;
	logic                        pm_out;
	logic                        pm_prev;
	logic                        meas_fall;
	logic                        arm_prev;
	logic                        armed;
	logic                        gate;
	logic                        done;
	logic [`GFC_ACC_W-1:0]       acc;

	// 40 MHz into four phases gives the 10 MHz reference; the processor
	// clock comes from the same source through a halving stage
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			osc_phase    <= 2'h0;
			int_ref_prev <= 1'b0;
			cpu_clk_o    <= 1'b0;
		end
		else
		begin
			osc_phase    <= osc_phase + 2'h1;
			int_ref_prev <= int_ref;
			if (int_ref && !int_ref_prev)
				cpu_clk_o <= ~cpu_clk_o;
		end
	end

	assign int_ref = osc_phase[1];

	// activity detector: any edge retriggers the hold timer
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ext_prev  <= 1'b0;
			ext_timer <= 8'h00;
			ref_prev  <= 1'b0;
		end
		else
		begin
			ext_prev <= ext_ref_i;
			ref_prev <= ref_sel;
			if (ext_prev != ext_ref_i)
				ext_timer <= 8'(`GFC_EXT_HOLD_CYC);
			else if (ext_timer != 8'h00)
				ext_timer <= ext_timer - 8'h01;
		end
	end

	assign ext_present = (ext_timer != 8'h00);
	assign ref_sel     = ext_present ? ext_prev : int_ref;
	assign ref_rise    = ref_sel & ~ref_prev;

	// measurement input multiplexer
	always_comb
	begin
		case (gfc_pkg::gfc_in_sel_t'({port.input_sel_hi, port.input_sel_lo}))
			gfc_pkg::GFC_IN_SOURCE:   meas_in = source_freq_i;
			gfc_pkg::GFC_IN_ANALYZER: meas_in = analyzer_freq_in_i;
			gfc_pkg::GFC_IN_EXT_REF:  meas_in = ext_prev;
			gfc_pkg::GFC_IN_INT_REF:  meas_in = int_ref;
			default:                  meas_in = 1'b0;
		endcase
	end

	// divider outputs; the divide-by-one tap is also held high on preset
	always_comb
	begin
		div_out[0] = !port.arm_n | meas_in;
		for (int k = 1; k <= `GFC_STAGES; k++)
			div_out[k] = dec_out(dec_cnt[k]);
	end

	// ripple chain: each stage steps on the fall of the one before,
	// one clock late per stage, as a ripple counter would be
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div_prev <= '1;
			for (int k = 1; k <= `GFC_STAGES; k++)
				dec_cnt[k] <= `GFC_DEC_LAST;
		end
		else if (!port.arm_n)
		begin
			div_prev <= '1;
			for (int k = 1; k <= `GFC_STAGES; k++)
				dec_cnt[k] <= `GFC_DEC_LAST;
		end
		else
		begin
			div_prev <= div_out;
			for (int k = 1; k <= `GFC_STAGES; k++)
				if (falls(div_prev[k-1], div_out[k-1]))
					dec_cnt[k] <= (dec_cnt[k] == `GFC_DEC_LAST) ?
						4'h0 : dec_cnt[k] + 4'h1;
		end
	end

	// period multiplexer; codes above the last decade take the longest
	assign period_sel = {port.period_sel_b2, port.period_sel_b1,
		port.period_sel_b0};

	always_comb
	begin
		if (period_sel >= 3'(`GFC_STAGES))
			pm_out = div_out[`GFC_STAGES];
		else
			pm_out = div_out[period_sel];
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pm_prev <= 1'b1;
		else
			pm_prev <= pm_out;
	end

	// rising edge of the inverted tap is the gate clock
	assign meas_fall = falls(pm_prev, pm_out);

	// arm latch
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			arm_prev <= 1'b1;
			armed    <= 1'b0;
		end
		else
		begin
			arm_prev <= port.arm_n;
			if (gate)
				armed <= 1'b0;
			else if (port.arm_n && !arm_prev)
				armed <= 1'b1;
		end
	end

	// gate flip-flop: d is the arm latch, so it opens for one period
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			gate <= 1'b0;
		else if (!port.arm_n)
			gate <= 1'b0;
		else if (meas_fall)
			gate <= armed;
	end

	// completion flag, dropped by the next arm
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			done <= 1'b0;
		else if (!port.arm_n)
			done <= 1'b0;
		else if (gate && meas_fall && !armed)
			done <= 1'b1;
	end

	// accumulator; msb freezes it so it never wraps
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			acc <= '0;
		else if (!port.acc_clear_n)
			acc <= '0;
		else if (gate && ref_rise && !acc[`GFC_ACC_W-1])
			acc <= acc + `GFC_ACC_W'(1);
	end

	// host-facing port and indicators
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			port.count      <= '0;
			port.count_done <= 1'b0;
			port.status     <= '0;
			ext_ref_led_o   <= 1'b0;
			armed_led_o     <= 1'b0;
			gate_led_o      <= 1'b0;
			overflow_led_o  <= 1'b0;
		end
		else
		begin
			port.count      <= acc;
			port.count_done <= done;
			port.status     <= {gate, ext_present, option_sw_i};
			ext_ref_led_o   <= ext_present;
			armed_led_o     <= armed;
			gate_led_o      <= gate;
			overflow_led_o  <= acc[`GFC_ACC_W-1];
		end
	end

endmodule

// file: rtl/gfc_consts.svh
// timing counts and field positions for the gated frequency counter
`ifndef GFC_CONSTS_SVH
`define GFC_CONSTS_SVH

// system clock period
`define GFC_CLK_NS 25

// external reference is dropped after this much silence
`define GFC_EXT_HOLD_NS 2000
`define GFC_EXT_HOLD_CYC (`GFC_EXT_HOLD_NS / `GFC_CLK_NS)

// host low times on arm and clear lines (least times, rounded up)
`define GFC_ARM_LOW_NS 100
`define GFC_ARM_LOW_CYC ((`GFC_ARM_LOW_NS + `GFC_CLK_NS - 1) / `GFC_CLK_NS)
`define GFC_CLR_LOW_NS 100
`define GFC_CLR_LOW_CYC ((`GFC_CLR_LOW_NS + `GFC_CLK_NS - 1) / `GFC_CLK_NS)

// widths
`define GFC_ACC_W 26
`define GFC_OPT_W 8
`define GFC_STAT_W 10
`define GFC_STAGES 6

// status port layout
`define GFC_STAT_OPT_LSB 0
`define GFC_STAT_EXT_BIT 8
`define GFC_STAT_GATE_BIT 9

// decade stage values
`define GFC_DEC_LAST 4'h9
`define GFC_DEC_HALF 4'h5

`endif

// file: rtl/gfc_pkg.sv
// types for the gated frequency counter: input select codes for the counter end, sequencer states for the host end
package gfc_pkg;

	// measurement input select codes
	typedef enum logic [1:0] {
		GFC_IN_SOURCE   = 2'h0,
		GFC_IN_ANALYZER = 2'h1,
		GFC_IN_EXT_REF  = 2'h2,
		GFC_IN_INT_REF  = 2'h3
	} gfc_in_sel_t;

	// host sequencer states
	typedef enum logic [1:0] {
		GFC_H_IDLE,
		GFC_H_CLEAR,
		GFC_H_ARM,
		GFC_H_WAIT
	} gfc_host_state_t;

endpackage

// file: rtl/gfc_if.sv
// parallel port lines between the counter and its host
`timescale 1ns/10ps
`include "gfc_consts.svh"

interface gfc_if;
	logic                    input_sel_lo;
	logic                    input_sel_hi;
	logic                    period_sel_b0;
	logic                    period_sel_b1;
	logic                    period_sel_b2;
	logic                    arm_n;
	logic                    acc_clear_n;
	logic [`GFC_ACC_W-1:0]   count;
	logic                    count_done;
	logic [`GFC_STAT_W-1:0]  status;

	modport dev (
		input  input_sel_lo,
		input  input_sel_hi,
		input  period_sel_b0,
		input  period_sel_b1,
		input  period_sel_b2,
		input  arm_n,
		input  acc_clear_n,
		output count,
		output count_done,
		output status
	);

	modport host (
		output input_sel_lo,
		output input_sel_hi,
		output period_sel_b0,
		output period_sel_b1,
		output period_sel_b2,
		output arm_n,
		output acc_clear_n,
		input  count,
		input  count_done,
		input  status
	);
endinterface

// file: rtl/gfc_host.sv
// host end: drives selects, arm and clear, collects the count
`timescale 1ns/10ps
`include "gfc_consts.svh"

module gfc_host (
	// clock and reset
	input  wire logic                    clock_i,
	input  wire logic                    rst_n_i,
	// parallel port to the counter
	gfc_if.host                          port,
	// user commands
	input  wire logic                    start_i,
	input  wire logic                    clear_i,
	input  wire logic [1:0]              input_sel_i,
	input  wire logic [2:0]              period_sel_i,
	// user results
	output logic                         busy_o,
	output logic                         result_valid_o,
	output logic [`GFC_ACC_W-1:0]        result_o,
	output logic [`GFC_STAT_W-1:0]       status_o
);

	gfc_pkg::gfc_host_state_t  state;
	logic [7:0]                low_cnt;

	// sequencer: arm or clear pulse low, then after an arm wait for completion
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state              <= gfc_pkg::GFC_H_IDLE;
			low_cnt            <= 8'h00;
			port.arm_n         <= 1'b1;
			port.acc_clear_n   <= 1'b1;
			port.input_sel_lo  <= 1'b0;
			port.input_sel_hi  <= 1'b0;
			port.period_sel_b0 <= 1'b0;
			port.period_sel_b1 <= 1'b0;
			port.period_sel_b2 <= 1'b0;
			busy_o             <= 1'b0;
			result_valid_o     <= 1'b0;
			result_o           <= '0;
		end
		else
		begin
			result_valid_o <= 1'b0;
			case (state)
				gfc_pkg::GFC_H_IDLE:
					if (clear_i)
					begin
						port.acc_clear_n <= 1'b0;
						low_cnt          <= 8'h00;
						busy_o           <= 1'b1;
						state            <= gfc_pkg::GFC_H_CLEAR;
					end
					else if (start_i)
					begin
						{port.input_sel_hi, port.input_sel_lo} <= input_sel_i;
						{port.period_sel_b2, port.period_sel_b1,
							port.period_sel_b0} <= period_sel_i;
						port.arm_n <= 1'b0;
						low_cnt    <= 8'h00;
						busy_o     <= 1'b1;
						state      <= gfc_pkg::GFC_H_ARM;
					end
				gfc_pkg::GFC_H_CLEAR:
					if (low_cnt == 8'(`GFC_CLR_LOW_CYC - 1))
					begin
						port.acc_clear_n <= 1'b1;
						busy_o           <= 1'b0;
						state            <= gfc_pkg::GFC_H_IDLE;
					end
					else
						low_cnt <= low_cnt + 8'h01;
				gfc_pkg::GFC_H_ARM:
					if (low_cnt == 8'(`GFC_ARM_LOW_CYC - 1))
					begin
						port.arm_n <= 1'b1;
						state      <= gfc_pkg::GFC_H_WAIT;
					end
					else
						low_cnt <= low_cnt + 8'h01;
				gfc_pkg::GFC_H_WAIT:
					if (port.count_done)
					begin
						result_o       <= port.count;
						result_valid_o <= 1'b1;
						busy_o         <= 1'b0;
						state          <= gfc_pkg::GFC_H_IDLE;
					end
				default:
					state <= gfc_pkg::GFC_H_IDLE;
			endcase
		end
	end

	// status port copied every cycle
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			status_o <= '0;
		else
			status_o <= port.status;
	end

endmodule

// file: sim/gfc_sva.sv
// checker on the port lines between the counter and its host
`timescale 1ns/10ps
`include "gfc_consts.svh"

module gfc_sva (
	// clock and reset
	input  wire logic                    clock_i,
	input  wire logic                    rst_n_i,
	// host driven lines
	input  wire logic                    input_sel_lo,
	input  wire logic                    input_sel_hi,
	input  wire logic                    period_sel_b0,
	input  wire logic                    period_sel_b1,
	input  wire logic                    period_sel_b2,
	input  wire logic                    arm_n,
	input  wire logic                    acc_clear_n,
	// counter driven lines
	input  wire logic [`GFC_ACC_W-1:0]   count,
	input  wire logic                    count_done,
	input  wire logic [`GFC_STAT_W-1:0]  status
);
	logic [2:0] gate_hist;
	logic [2:0] clr_hist;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// count copy lags the gate by up to three cycles, so keep a history
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			gate_hist <= 3'h0;
			clr_hist  <= 3'h0;
		end
		else
		begin
			gate_hist <= {gate_hist[1:0], status[`GFC_STAT_GATE_BIT]};
			clr_hist  <= {clr_hist[1:0], !acc_clear_n};
		end
	end

	sequence arm_held;
		!arm_n [*3];
	endsequence

	sequence clr_held;
		!acc_clear_n [*3];
	endsequence

	arm_gate_clear_a: assert property (
		arm_held |-> !status[`GFC_STAT_GATE_BIT])
		else $error("gate open while arm held low");
	arm_done_clear_a: assert property (arm_held |-> !count_done)
		else $error("count done while arm held low");
	clear_zeroes_a: assert property (clr_held |-> count == 26'h0000000)
		else $error("count not zero while clear held");
	arm_low_time_a: assert property ($fell(arm_n) |-> !arm_n [*4])
		else $error("arm low too short");
	clear_low_time_a: assert property (
		$fell(acc_clear_n) |-> !acc_clear_n [*4])
		else $error("clear low too short");
	done_gate_excl_a: assert property (
		count_done |-> !status[`GFC_STAT_GATE_BIT])
		else $error("count done while gate open");
	gate_end_done_a: assert property (
		$fell(status[`GFC_STAT_GATE_BIT]) && arm_n |-> ##[0:2] count_done)
		else $error("no count done after gate closed");
	count_held_a: assert property (count_done && acc_clear_n
		&& $past(acc_clear_n) && $past(acc_clear_n, 2) |=> $stable(count))
		else $error("count moved after completion");
	gated_count_a: assert property (
		!$stable(count) |-> (|gate_hist) || (|clr_hist))
		else $error("count moved outside gate");
	overflow_stop_a: assert property (count[`GFC_ACC_W-1] && acc_clear_n
		&& $past(acc_clear_n) && $past(acc_clear_n, 2) |=> $stable(count))
		else $error("count moved past top bit");
	select_hold_a: assert property (arm_n && $past(arm_n) && !count_done
		|-> $stable({input_sel_hi, input_sel_lo, period_sel_b2,
		period_sel_b1, period_sel_b0}))
		else $error("selects moved during measurement");
endmodule

// file: sim/test_gated_frequency_counter.sv
// self-checking bench joining the counter and host ends
`timescale 1ns/10ps
`include "gfc_consts.svh"

module test_gated_frequency_counter;
	logic                    clock_i;
	logic                    rst_n_i;
	logic                    ext_on;
	logic                    start_i;
	logic                    clear_i;
	logic [1:0]              input_sel_i;
	logic [2:0]              period_sel_i;
	logic [`GFC_OPT_W-1:0]   option_sw_i;
	logic                    busy_o;
	logic                    result_valid_o;
	logic [`GFC_ACC_W-1:0]   result_o;
	logic [`GFC_STAT_W-1:0]  status_o;
	logic                    ext_ref_led_o;
	logic                    armed_led_o;
	logic                    gate_led_o;
	logic                    overflow_led_o;
	logic                    cpu_clk_o;
	logic [31:0]             seed;
	int                      phase;
	int                      miscompares;
	int                      tests_run;
	int                      in_per [4];

	gfc_if bus ();
	gfc_device gfc_device_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.port(bus), .source_freq_i((phase % 8) < 4),
		.analyzer_freq_in_i((phase % 12) < 6),
		.ext_ref_i(ext_on && ((phase % 6) < 3)), .option_sw_i(option_sw_i),
		.ext_ref_led_o(ext_ref_led_o), .armed_led_o(armed_led_o),
		.gate_led_o(gate_led_o), .overflow_led_o(overflow_led_o),
		.cpu_clk_o(cpu_clk_o));
	gfc_host gfc_host_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .port(bus),
		.start_i(start_i), .clear_i(clear_i), .input_sel_i(input_sel_i),
		.period_sel_i(period_sel_i), .busy_o(busy_o),
		.result_valid_o(result_valid_o), .result_o(result_o),
		.status_o(status_o));
	gfc_sva gfc_sva_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.input_sel_lo(bus.input_sel_lo), .input_sel_hi(bus.input_sel_hi),
		.period_sel_b0(bus.period_sel_b0), .period_sel_b1(bus.period_sel_b1),
		.period_sel_b2(bus.period_sel_b2), .arm_n(bus.arm_n),
		.acc_clear_n(bus.acc_clear_n), .count(bus.count),
		.count_done(bus.count_done), .status(bus.status));

	initial clock_i = 1'b0;
	always #12.5 clock_i = ~clock_i;
	always @(posedge clock_i) #2 phase <= phase + 1;

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// floor of gate length over reference period; the count may round up
	function int exp_count(input int p, input int sel, input int ref_p);
		int div;
		div = 1;
		for (int k = 0; k < p; k++)
			div = div * 10;
		return in_per[sel] * div / ref_p;
	endfunction

	task results();
		$display("comparisons %0d, miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] want, input int sl);
		tests_run++;
		if (got !== want && (sl == 0 || (got !== want + 1 && got !== want - 1)))
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	task tick();
		@(posedge clock_i);
		#2;
	endtask

	task do_clear();
		int n;
		clear_i = 1'b1;
		tick();
		clear_i = 1'b0;
		n = 0;
		while (busy_o !== 1'b0 && n < 50)
		begin
			tick();
			n++;
		end
		check(busy_o, 0, 0);
		check(bus.count, 0, 0);
		check(overflow_led_o, 0, 0);
	endtask

	// poke raises clear mid-run, which the busy host must ignore
	task meas(input int sel, input int p, input bit poke);
		int n;
		int lim;
		int want;
		logic [31:0] r;
		logic sa;
		logic sg;
		want = exp_count(p, sel, ext_on ? 6 : 4);
		lim = want * 4 * (ext_on ? 6 : 4) + 200;
		sa = 1'b0;
		sg = 1'b0;
		r = rnd();
		option_sw_i = r[7:0];
		input_sel_i = sel[1:0];
		period_sel_i = p[2:0];
		start_i = 1'b1;
		tick();
		start_i = 1'b0;
		n = 0;
		while (result_valid_o !== 1'b1 && n < lim)
		begin
			clear_i = poke && n == 30;
			sa = sa | (armed_led_o === 1'b1);
			sg = sg | (gate_led_o === 1'b1);
			tick();
			n++;
		end
		clear_i = 1'b0;
		check(n < lim, 1, 0);
		check(result_o, want, 1);
		check({sa, sg}, 2'h3, 0);
		check(status_o[7:0], option_sw_i, 0);
		check(status_o[`GFC_STAT_EXT_BIT], ext_on, 0);
		check(status_o[`GFC_STAT_GATE_BIT], 0, 0);
		check(busy_o, 0, 0);
		repeat (20) tick();
		check(bus.count, result_o, 0);
		check(bus.count_done, 1, 0);
	endtask

	initial
	begin
		repeat (60000) @(posedge clock_i);
		miscompares++;
		results();
	end

	initial
	begin
		logic [31:0] r;
		logic c0;
		int k;
		in_per = '{8, 12, 6, 4};
		seed = 32'h00013e87;
		ext_on = 1'b0;
		start_i = 1'b0;
		clear_i = 1'b0;
		input_sel_i = 2'h0;
		period_sel_i = 3'h0;
		option_sw_i = 8'h00;
		rst_n_i = 1'b0;
		repeat (10) @(posedge clock_i);
		#2 rst_n_i = 1'b1;
		tick();
		check(ext_ref_led_o, 0, 0);
		k = 0;
		repeat (80)
		begin
			c0 = cpu_clk_o;
			tick();
			k = k + (c0 === 1'b0 && cpu_clk_o === 1'b1);
		end
		check(k, 10, 0);
		for (int s = 0; s < 4; s++)
			for (int p = 0; p < 3; p++)
				if (s != 2)
				begin
					do_clear();
					meas(s, p, 0);
				end
		do_clear();
		meas(3, 3, 1);
		ext_on = 1'b1;
		repeat (20) tick();
		check(ext_ref_led_o, 1, 0);
		for (int s = 0; s < 4; s++)
			for (int p = 0; p < 3; p++)
			begin
				do_clear();
				meas(s, p, 0);
			end
		ext_on = 1'b0;
		repeat (100) tick();
		check(ext_ref_led_o, 0, 0);
		repeat (8)
		begin
			r = rnd();
			do_clear();
			meas(r[1:0] == 2'h2 ? 0 : r[1:0], r[7:4] % 3, 0);
		end
		results();
	end
endmodule
